// ==== hw/psl_consts.vh ====
// Functional notes
// - Supply status bit 24 reads 1 while the on-chip oscillator is stable; it is read-only.
// - Supply status bit 19 reads 1 when the PLL rail is good, bit 16 when the core rail is.
// - Bit 9 reads 1 while the analog switcher limits current, bit 8 for the core switcher.
// - Bit 1 reads 1 while the analog switcher is in soft-start, bit 0 for the core switcher.
// - Core level holds a writable 7-bit code in bits 6:0, 10 mV per step, 0 is 0.60V, 70 is 1.30V.
// - After reset both level codes are loaded from the boot strap pins, not from constants.
// - PLL regulator level holds a writable 3-bit code in bits 2:0, 100 mV per step, 0.6V to 1.3V.
`ifndef PSL_CONSTS_VH
`define PSL_CONSTS_VH

// Register offsets (byte addresses)
`define PSL_OFS_SUPPLY_STATUS 8'h30
`define PSL_OFS_CORE_LEVEL    8'h34
`define PSL_OFS_PLL_LEVEL     8'h40
`define PSL_OFS_IRQ_STATUS    8'h44
`define PSL_OFS_IRQ_MASK      8'h48

// Supply status field positions
`define PSL_BIT_OSC_STABLE    24
`define PSL_BIT_PLL_GOOD      19
`define PSL_BIT_CORE_GOOD     16
`define PSL_BIT_ANA_LIMIT     9
`define PSL_BIT_CORE_LIMIT    8
`define PSL_BIT_ANA_SOFT      1
`define PSL_BIT_CORE_SOFT     0

// Compact index of each status flag
`define PSL_IDX_CORE_SOFT     0
`define PSL_IDX_ANA_SOFT      1
`define PSL_IDX_CORE_LIMIT    2
`define PSL_IDX_ANA_LIMIT     3
`define PSL_IDX_CORE_GOOD     4
`define PSL_IDX_PLL_GOOD      5
`define PSL_IDX_OSC_STABLE    6
`define PSL_NUM_FLAGS         7

// Level fields
`define PSL_CORE_CODE_W       7
`define PSL_CORE_CODE_MAX     7'h46
`define PSL_PLL_CODE_W        3

// Strap and synchroniser
`define PSL_MODE_W            2
`define PSL_SYNC_STAGES       2
`define PSL_STRAP_WAIT        2'h2

// Strap tables, one code per mode, mode 0 in the low bits
`define PSL_CORE_STRAP_TABLE  28'h2841E28
`define PSL_PLL_STRAP_TABLE   12'h654

`endif

// ==== hw/psl_sync.v ====
`timescale 1ns/1ps
`default_nettype none

module psl_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  // Two flip-flops per bit, first stage read only by the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : gSync
      reg stage1_reg;
      reg stage2_reg;
      always @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
        end
        else
        begin
          stage1_reg <= asyncIn[i];
          stage2_reg <= stage1_reg;
        end
      end
      assign syncOut[i] = stage2_reg;
    end
  endgenerate

endmodule // psl_sync

`default_nettype wire

// ==== hw/psl_power_regs.v ====
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "psl_consts.vh"

module psl_power_regs #(
  parameter [27:0] CORE_STRAP_TABLE = `PSL_CORE_STRAP_TABLE,
  parameter [11:0] PLL_STRAP_TABLE  = `PSL_PLL_STRAP_TABLE
) (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWrEn,
  input  wire        regRdEn,
  output wire [31:0] regRdData,
  output wire        irqOut,
  input  wire [1:0]  modePins,
  input  wire        oscStable,
  input  wire        pllRailGood,
  input  wire        coreRailGood,
  input  wire        anaSwitchLimit,
  input  wire        coreSwitchLimit,
  input  wire        anaSwitchSoftStart,
  input  wire        coreSwitchSoftStart,
  output wire [6:0]  coreLevelCode,
  output wire [2:0]  pllLevelCode,
  output wire        strapLoaded
);

  // Start-up states
  localparam [2:0] ST_WAIT = 3'h1;
  localparam [2:0] ST_LOAD = 3'h2;
  localparam [2:0] ST_RUN  = 3'h4;

  // Flag count and synchroniser width
  localparam NF = `PSL_NUM_FLAGS;
  localparam SW = `PSL_MODE_W + NF;

  // Spread compact flags onto the status word layout
  function [31:0] spreadFlags;
    input [NF-1:0] f;
    begin
      spreadFlags = 32'h0;
      spreadFlags[`PSL_BIT_OSC_STABLE] = f[`PSL_IDX_OSC_STABLE];
      spreadFlags[`PSL_BIT_PLL_GOOD]   = f[`PSL_IDX_PLL_GOOD];
      spreadFlags[`PSL_BIT_CORE_GOOD]  = f[`PSL_IDX_CORE_GOOD];
      spreadFlags[`PSL_BIT_ANA_LIMIT]  = f[`PSL_IDX_ANA_LIMIT];
      spreadFlags[`PSL_BIT_CORE_LIMIT] = f[`PSL_IDX_CORE_LIMIT];
      spreadFlags[`PSL_BIT_ANA_SOFT]   = f[`PSL_IDX_ANA_SOFT];
      spreadFlags[`PSL_BIT_CORE_SOFT]  = f[`PSL_IDX_CORE_SOFT];
    end
  endfunction

  // Gather status word bits into compact flags
  function [NF-1:0] gatherFlags;
    input [31:0] w;
    begin
      gatherFlags = {NF{1'b0}};
      gatherFlags[`PSL_IDX_OSC_STABLE] = w[`PSL_BIT_OSC_STABLE];
      gatherFlags[`PSL_IDX_PLL_GOOD]   = w[`PSL_BIT_PLL_GOOD];
      gatherFlags[`PSL_IDX_CORE_GOOD]  = w[`PSL_BIT_CORE_GOOD];
      gatherFlags[`PSL_IDX_ANA_LIMIT]  = w[`PSL_BIT_ANA_LIMIT];
      gatherFlags[`PSL_IDX_CORE_LIMIT] = w[`PSL_BIT_CORE_LIMIT];
      gatherFlags[`PSL_IDX_ANA_SOFT]   = w[`PSL_BIT_ANA_SOFT];
      gatherFlags[`PSL_IDX_CORE_SOFT]  = w[`PSL_BIT_CORE_SOFT];
    end
  endfunction

  // Synchronised pins and flags
  wire [SW-1:0] rawPins;
  wire [SW-1:0] syncPins;
  wire [NF-1:0] flagsNow;
  wire [1:0]    modeSync;

  // Start-up sequencer
  reg  [2:0]    state_reg;
  reg  [2:0]    state_next;
  reg  [1:0]    waitCnt_reg;
  reg  [1:0]    waitCnt_next;

  // Level registers
  reg  [6:0]    coreLevel_reg;
  reg  [6:0]    coreLevel_next;
  reg  [2:0]    pllLevel_reg;
  reg  [2:0]    pllLevel_next;

  // Interrupt state
  reg  [NF-1:0] flagsPrev_reg;
  reg  [NF-1:0] irqStat_reg;
  reg  [NF-1:0] irqStat_next;
  reg  [NF-1:0] irqMask_reg;
  reg  [NF-1:0] irqMask_next;

  // Read path and output flops
  reg  [31:0]   rdData_reg;
  reg  [31:0]   rdData_next;
  reg           irq_reg;
  reg           strapDone_reg;

  // Combinational helpers
  reg  [6:0]    strapCore;
  reg  [6:0]    strapCoreSafe;
  reg  [2:0]    strapPll;
  reg  [6:0]    coreWrCode;

  // Decoded strobes and events
  wire          wrCore;
  wire          wrPll;
  wire          wrMask;
  wire          rdIrqStat;
  wire [NF-1:0] events;

  // Pins from the analog side and the straps
  assign rawPins = {modePins,
                    oscStable, pllRailGood, coreRailGood,
                    anaSwitchLimit, coreSwitchLimit,
                    anaSwitchSoftStart, coreSwitchSoftStart};

  // Every pin passes two flip-flops first
  psl_sync #(
    .WIDTH (SW)
  ) uSync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .asyncIn (rawPins),
    .syncOut (syncPins)
  );

  // Split synchronised flags from mode pins
  assign flagsNow = syncPins[NF-1:0];
  assign modeSync = syncPins[SW-1:NF];

  // Strap decode from the mode pins
  always @*
  begin
    strapCore = 7'h00;
    strapPll  = 3'h0;
    case (modeSync)
      2'h0:
      begin
        strapCore = CORE_STRAP_TABLE[6:0];
        strapPll  = PLL_STRAP_TABLE[2:0];
      end
      2'h1:
      begin
        strapCore = CORE_STRAP_TABLE[13:7];
        strapPll  = PLL_STRAP_TABLE[5:3];
      end
      2'h2:
      begin
        strapCore = CORE_STRAP_TABLE[20:14];
        strapPll  = PLL_STRAP_TABLE[8:6];
      end
      default:
      begin
        strapCore = CORE_STRAP_TABLE[27:21];
        strapPll  = PLL_STRAP_TABLE[11:9];
      end
    endcase
  end

  // Decoded register accesses
  assign wrCore    = regWrEn && (regAddr == `PSL_OFS_CORE_LEVEL) && state_reg[2];
  assign wrPll     = regWrEn && (regAddr == `PSL_OFS_PLL_LEVEL) && state_reg[2];
  assign wrMask    = regWrEn && (regAddr == `PSL_OFS_IRQ_MASK);
  assign rdIrqStat = regRdEn && (regAddr == `PSL_OFS_IRQ_STATUS);

  // Core code above the top step is held at 1.30V
  always @*
  begin
    coreWrCode = regWrData[6:0];
    if (regWrData[6:0] > `PSL_CORE_CODE_MAX)
    begin
      coreWrCode = `PSL_CORE_CODE_MAX;
    end
  end

  // Strap code above the top step is held at 1.30V too
  always @*
  begin
    strapCoreSafe = strapCore;
    if (strapCore > `PSL_CORE_CODE_MAX)
    begin
      strapCoreSafe = `PSL_CORE_CODE_MAX;
    end
  end

  // Start-up sequencing: wait for synced straps, load, run
  always @*
  begin
    state_next   = state_reg;
    waitCnt_next = waitCnt_reg;
    case (state_reg)
      ST_WAIT:
      begin
        if (waitCnt_reg == `PSL_STRAP_WAIT)
        begin
          state_next = ST_LOAD;
        end
        else
        begin
          waitCnt_next = waitCnt_reg + 2'h1;
        end
      end
      ST_LOAD:
      begin
        state_next = ST_RUN;
      end
      ST_RUN:
      begin
        state_next = ST_RUN;
      end
      default:
      begin
        state_next   = ST_WAIT;
        waitCnt_next = 2'h0;
      end
    endcase
  end

  // Level registers: strap load then software writes
  always @*
  begin
    coreLevel_next = coreLevel_reg;
    pllLevel_next  = pllLevel_reg;
    if (state_reg == ST_LOAD)
    begin
      coreLevel_next = strapCoreSafe;
      pllLevel_next  = strapPll;
    end
    else
    begin
      if (wrCore)
      begin
        coreLevel_next = coreWrCode;
      end
      if (wrPll)
      begin
        pllLevel_next = regWrData[2:0];
      end
    end
  end

  // Any change of a status flag is an event
  assign events = flagsNow ^ flagsPrev_reg;

  // Sticky events, cleared by reading; a new event wins
  always @*
  begin
    irqStat_next = irqStat_reg;
    if (rdIrqStat)
    begin
      irqStat_next = {NF{1'b0}};
    end
    irqStat_next = irqStat_next | events;
  end

  // Mask uses the status word layout
  always @*
  begin
    irqMask_next = irqMask_reg;
    if (wrMask)
    begin
      irqMask_next = gatherFlags(regWrData);
    end
  end

  // Read mux; reserved and unmapped bits read as zero
  always @*
  begin
    rdData_next = 32'h0;
    if (regRdEn)
    begin
      case (regAddr)
        `PSL_OFS_SUPPLY_STATUS:
        begin
          rdData_next = spreadFlags(flagsNow);
        end
        `PSL_OFS_CORE_LEVEL:
        begin
          rdData_next = {25'h0, coreLevel_reg};
        end
        `PSL_OFS_PLL_LEVEL:
        begin
          rdData_next = {29'h0, pllLevel_reg};
        end
        `PSL_OFS_IRQ_STATUS:
        begin
          rdData_next = spreadFlags(irqStat_reg);
        end
        `PSL_OFS_IRQ_MASK:
        begin
          rdData_next = spreadFlags(irqMask_reg);
        end
        default:
        begin
          rdData_next = 32'h0;
        end
      endcase
    end
  end

  // State registers
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg     <= ST_WAIT;
      waitCnt_reg   <= 2'h0;
      coreLevel_reg <= 7'h00;
      pllLevel_reg  <= 3'h0;
      flagsPrev_reg <= {NF{1'b0}};
      irqStat_reg   <= {NF{1'b0}};
      irqMask_reg   <= {NF{1'b0}};
      rdData_reg    <= 32'h0;
      irq_reg       <= 1'b0;
      strapDone_reg <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      waitCnt_reg   <= waitCnt_next;
      coreLevel_reg <= coreLevel_next;
      pllLevel_reg  <= pllLevel_next;
      flagsPrev_reg <= flagsNow;
      irqStat_reg   <= irqStat_next;
      irqMask_reg   <= irqMask_next;
      rdData_reg    <= rdData_next;
      irq_reg       <= |(irqStat_reg & irqMask_reg);
      strapDone_reg <= (state_reg == ST_LOAD) || strapDone_reg;
    end
  end

  // Outputs straight from flip-flops
  assign regRdData     = rdData_reg;
  assign irqOut        = irq_reg;
  assign coreLevelCode = coreLevel_reg;
  assign pllLevelCode  = pllLevel_reg;
  assign strapLoaded   = strapDone_reg;

endmodule // psl_power_regs

`default_nettype wire

// ==== tb/psl_power_regs_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module psl_regs_chk (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [31:0] regRdData,
  input wire logic [6:0]  coreLevelCode,
  input wire logic [2:0]  pllLevelCode,
  input wire logic        strapLoaded
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Accepted accesses
  sequence rd_s(logic [7:0] a);
    regRdEn && regAddr == a;
  endsequence
  sequence wr_s(logic [7:0] a);
    regWrEn && regAddr == a && strapLoaded;
  endsequence

  // Read port and field checks
  rd_idle_a: assert property (!regRdEn |=> regRdData == 32'h0)
    else $error("read data not zero when idle");
  core_res_a: assert property (rd_s(8'h34) |=> regRdData[31:7] == 25'h0)
    else $error("core level reserved bits set");
  pll_res_a: assert property (rd_s(8'h40) |=> regRdData[31:3] == 29'h0)
    else $error("pll level reserved bits set");
  stat_res_a: assert property (rd_s(8'h30) |=> (regRdData & ~32'h01090303) == 32'h0)
    else $error("status reserved bits set");
  core_max_a: assert property (coreLevelCode <= 7'h46)
    else $error("core code above 70");
  core_wr_a: assert property (wr_s(8'h34) |=> coreLevelCode ==
    (($past(regWrData[6:0]) > 7'h46) ? 7'h46 : $past(regWrData[6:0])))
    else $error("core code not written");
  pll_wr_a: assert property (wr_s(8'h40) |=> pllLevelCode == $past(regWrData[2:0]))
    else $error("pll code not written");
  strap_hold_a: assert property (strapLoaded |=> strapLoaded)
    else $error("strap loaded flag dropped");
endmodule // psl_regs_chk

bind psl_power_regs psl_regs_chk chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .coreLevelCode(coreLevelCode), .pllLevelCode(pllLevelCode), .strapLoaded(strapLoaded));

`default_nettype wire

// ==== tb/psl_power_regs_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module psl_power_regs_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic [1:0]  modePins = 2'h0;
  logic [6:0]  pinVec = 7'h00;
  wire  [31:0] regRdData;
  wire         irqOut;
  wire  [6:0]  coreLevelCode;
  wire  [2:0]  pllLevelCode;
  wire         strapLoaded;
  integer      badCount = 0;
  integer      totalChecks = 0;
  integer      cycles = 0;
  integer      seedVal = 32'h51e6c002;
  logic [31:0] d;
  logic [31:0] q;
  logic [6:0]  c;

  psl_power_regs dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .irqOut(irqOut),
    .modePins(modePins), .oscStable(pinVec[6]), .pllRailGood(pinVec[5]),
    .coreRailGood(pinVec[4]), .anaSwitchLimit(pinVec[3]), .coreSwitchLimit(pinVec[2]),
    .anaSwitchSoftStart(pinVec[1]), .coreSwitchSoftStart(pinVec[0]),
    .coreLevelCode(coreLevelCode), .pllLevelCode(pllLevelCode), .strapLoaded(strapLoaded));

  // Clock and hang guard
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      badCount = badCount + 1;
      testDone;
    end
  end

  // Expected status word from the flag vector
  function automatic logic [31:0] statWord(input logic [6:0] v);
    statWord = {7'h0, v[6], 4'h0, v[5], 2'h0, v[4], 6'h0, v[3:2], 6'h0, v[1:0]};
  endfunction
  function automatic logic [6:0] clampCore(input logic [6:0] v);
    clampCore = (v > 7'h46) ? 7'h46 : v;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    totalChecks = totalChecks + 1;
    if (g !== e)
    begin
      badCount = badCount + 1;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic testDone;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    // Strap load per mode, with writes during the load window dropped
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk_sys);
      rst_n <= 1'b0;
      modePins <= m[1:0];
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      wr(8'h34, 32'hFFFFFFFF);
      wr(8'h40, 32'hFFFFFFFF);
      for (int i = 0; i < 10 && strapLoaded !== 1'b1; i++) @(posedge clk_sys);
      #1 chk("core strap", {25'h0, 7'(28'h2841E28 >> (7 * m))}, {25'h0, coreLevelCode});
      chk("pll strap", {29'h0, 3'(12'h654 >> (3 * m))}, {29'h0, pllLevelCode});
      chk("strap flag", 32'h1, {31'h0, strapLoaded});
    end
    // Level writes, random with corners, plus status and unmapped reads
    for (int i = 0; i < 12; i++)
    begin
      d = $random(seedVal);
      c = (i == 0) ? 7'h46 : (i == 1) ? 7'h47 : (i == 2) ? 7'h7F : (i == 3) ? 7'h00 : d[6:0];
      d[6:0] = c;
      wr(8'h34, d);
      chk("core code", {25'h0, clampCore(c)}, {25'h0, coreLevelCode});
      rd(8'h34, q);
      chk("core read", {25'h0, clampCore(c)}, q);
      wr(8'h40, d);
      rd(8'h40, q);
      chk("pll read", {29'h0, d[2:0]}, q);
      @(posedge clk_sys);
      pinVec <= 7'($random(seedVal));
      repeat (4) @(posedge clk_sys);
      wr(8'h30, 32'hFFFFFFFF);
      rd(8'h30, q);
      chk("status", statWord(pinVec), q);
      rd(8'h3C, q);
      chk("unmapped", 32'h0, q);
    end
    // Core level ramp, one 10 mV step every 27 clocks (1.08 us)
    c = clampCore(c);
    for (int s = 0; s < 8; s++)
    begin
      c = (c > 7'h23) ? c - 7'h1 : c + 7'h1;
      wr(8'h34, {25'h0, c});
      chk("core ramp", {25'h0, c}, {25'h0, coreLevelCode});
      repeat (25) @(posedge clk_sys);
    end
    // PLL regulator level raised one count per update
    wr(8'h40, 32'h0);
    for (int s = 1; s < 8; s++)
    begin
      wr(8'h40, 32'(s));
      chk("pll ramp", {29'h0, 3'(s)}, {29'h0, pllLevelCode});
    end
    // Masked then unmasked oscillator event
    wr(8'h48, 32'h0);
    rd(8'h44, q);
    rd(8'h44, q);
    chk("irq clear", 32'h0, q);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_sys);
      pinVec[6] <= ~pinVec[6];
      repeat (6) @(posedge clk_sys);
      #1 chk("irq line", {31'h0, k[0]}, {31'h0, irqOut});
      rd(8'h44, q);
      chk("irq status", 32'h01000000, q);
      repeat (3) @(posedge clk_sys);
      #1 chk("irq drop", 32'h0, {31'h0, irqOut});
      wr(8'h48, 32'h01000000);
    end
    rd(8'h48, q);
    chk("irq mask", 32'h01000000, q);
    testDone;
  end
endmodule // psl_power_regs_tb_top

`default_nettype wire
